// >>> logic/iex_regs.vh
`ifndef IEX_REGS_VH
`define IEX_REGS_VH

// Fixed upper four bits of the 7-bit target address
`define IEX_ADDR_FIXED 4'h3
`define IEX_ADDR_SEL_W 3
`define IEX_BYTE_W 8
`define IEX_BIT_CNT_W 4
`define IEX_BITS_PER_BYTE 4'h8
`define IEX_BIT_CNT_ZERO 4'h0
`define IEX_BIT_CNT_ONE 4'h1

// Direction bit values
`define IEX_DIR_READ 1'b1
`define IEX_DIR_WRITE 1'b0

// Reset values
`define IEX_PORT_OE_N_RST 8'hff
`define IEX_PORT_OUT_RST 8'h00
`define IEX_BYTE_RST 8'h00

// Clock and reset timing
`define IEX_CLK_PERIOD_NS 100
`define IEX_T_RESET_NS 400
`define IEX_POR_CNT_W 4
// Reset time in clock cycles, rounded up
`define IEX_POR_HOLD_CYCLES 4'h4

`endif

// >>> logic/iex_sync.v
`timescale 1ns/1ps
module iex_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire clk_in,
    input wire reset_n_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage;

////////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser; first stage feeds only the second
always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        stage <= RESET_VALUE;
        sync_out <= RESET_VALUE;
    end else begin
        stage <= async_in;
        sync_out <= stage;
    end
end

endmodule

// >>> logic/iex_por.v
`timescale 1ns/1ps
`include "iex_regs.vh"
module iex_por #(
    parameter CNT_W = `IEX_POR_CNT_W,
    parameter [CNT_W-1:0] HOLD_CYCLES = `IEX_POR_HOLD_CYCLES
) (
    input wire clk_in,
    input wire reset_n_in,
    input wire supply_good_in,
    output reg ready_out
);

reg [CNT_W-1:0] count;

////////////////////////////////////////////////////////////////////////////////
// Holds the block in reset until the supply is good, then a short settle time
always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        count <= {CNT_W{1'b0}};
        ready_out <= 1'b0;
    end else if (!supply_good_in) begin
        count <= {CNT_W{1'b0}};
        ready_out <= 1'b0;
    end else if (count != HOLD_CYCLES) begin
        count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
        ready_out <= 1'b0;
    end else begin
        ready_out <= 1'b1;
    end
end

endmodule

// >>> logic/iex_target.v
`timescale 1ns/1ps
`include "iex_regs.vh"
module iex_target (
    input wire clk_in,
    input wire reset_n_in,
    input wire supply_good_in,
    input wire scl_in,
    input wire sda_in,
    input wire [`IEX_ADDR_SEL_W-1:0] address_select_inputs_in,
    input wire [`IEX_BYTE_W-1:0] rd_data_in,
    input wire [`IEX_BYTE_W-1:0] port_cfg_in,
    input wire [`IEX_BYTE_W-1:0] port_data_in,
    output reg sda_out,
    output reg sda_oe_n_out,
    output reg [`IEX_BYTE_W-1:0] port_pins_out,
    output reg [`IEX_BYTE_W-1:0] port_pins_oe_n_out,
    output reg regs_reset_out,
    output reg [`IEX_BYTE_W-1:0] cmd_byte_out,
    output reg cmd_valid_out,
    output reg [`IEX_BYTE_W-1:0] wr_data_out,
    output reg wr_valid_out,
    output reg rd_load_out,
    output reg addressed_out,
    output reg read_mode_out,
    output reg abort_out
);

localparam [7:0] ST_IDLE = 8'h01;
localparam [7:0] ST_ADDR = 8'h02;
localparam [7:0] ST_ADDR_ACK = 8'h04;
localparam [7:0] ST_WR_BYTE = 8'h08;
localparam [7:0] ST_WR_ACK = 8'h10;
localparam [7:0] ST_RD_BYTE = 8'h20;
localparam [7:0] ST_RD_ACK = 8'h40;
localparam [7:0] ST_IGNORE = 8'h80;

wire [1:0] bus_sync;
wire [`IEX_ADDR_SEL_W-1:0] addr_sel;
wire por_ready;
wire supply_good;
wire scl;
wire sda;
reg scl_prev;
reg sda_prev;
wire scl_rise;
wire scl_fall;
wire start_cond;
wire stop_cond;
wire hold;
wire [6:0] own_addr;

reg [7:0] state;
reg [`IEX_BIT_CNT_W-1:0] bit_cnt;
reg [`IEX_BYTE_W-1:0] shift;
reg first_byte;
reg ctrl_acked;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and power-on reset

iex_sync #(
    .WIDTH(2),
    .RESET_VALUE(2'b11)
) u_bus_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in({scl_in, sda_in}),
    .sync_out(bus_sync)
);

iex_sync #(
    .WIDTH(`IEX_ADDR_SEL_W),
    .RESET_VALUE({`IEX_ADDR_SEL_W{1'b0}})
) u_addr_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(address_select_inputs_in),
    .sync_out(addr_sel)
);

iex_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
) u_supply_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(supply_good_in),
    .sync_out(supply_good)
);

iex_por u_por (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .supply_good_in(supply_good),
    .ready_out(por_ready)
);

assign scl = bus_sync[1];
assign sda = bus_sync[0];
assign hold = ~por_ready;
assign own_addr = {`IEX_ADDR_FIXED, addr_sel};

always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        scl_prev <= 1'b1;
        sda_prev <= 1'b1;
    end else begin
        scl_prev <= scl;
        sda_prev <= sda;
    end
end

assign scl_rise = scl & ~scl_prev;
assign scl_fall = ~scl & scl_prev;
assign start_cond = scl & scl_prev & sda_prev & ~sda;
assign stop_cond = scl & scl_prev & ~sda_prev & sda;

////////////////////////////////////////////////////////////////////////////////
// Port pin direction and register-file reset

always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        port_pins_oe_n_out <= `IEX_PORT_OE_N_RST;
        port_pins_out <= `IEX_PORT_OUT_RST;
        regs_reset_out <= 1'b1;
    end else if (hold) begin
        port_pins_oe_n_out <= `IEX_PORT_OE_N_RST;
        port_pins_out <= `IEX_PORT_OUT_RST;
        regs_reset_out <= 1'b1;
    end else begin
        // Configuration bit one means input, so driver off
        port_pins_oe_n_out <= port_cfg_in;
        port_pins_out <= port_data_in;
        regs_reset_out <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Bus state machine

always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        state <= ST_IDLE;
        bit_cnt <= `IEX_BIT_CNT_ZERO;
        shift <= `IEX_BYTE_RST;
        first_byte <= 1'b0;
        ctrl_acked <= 1'b0;
        sda_out <= 1'b0;
        sda_oe_n_out <= 1'b1;
        cmd_byte_out <= `IEX_BYTE_RST;
        cmd_valid_out <= 1'b0;
        wr_data_out <= `IEX_BYTE_RST;
        wr_valid_out <= 1'b0;
        rd_load_out <= 1'b0;
        addressed_out <= 1'b0;
        read_mode_out <= 1'b0;
        abort_out <= 1'b0;
    end else if (hold) begin
        state <= ST_IDLE;
        bit_cnt <= `IEX_BIT_CNT_ZERO;
        shift <= `IEX_BYTE_RST;
        first_byte <= 1'b0;
        ctrl_acked <= 1'b0;
        sda_oe_n_out <= 1'b1;
        cmd_byte_out <= `IEX_BYTE_RST;
        cmd_valid_out <= 1'b0;
        wr_data_out <= `IEX_BYTE_RST;
        wr_valid_out <= 1'b0;
        rd_load_out <= 1'b0;
        addressed_out <= 1'b0;
        read_mode_out <= 1'b0;
        abort_out <= 1'b0;
    end else begin
        cmd_valid_out <= 1'b0;
        wr_valid_out <= 1'b0;
        rd_load_out <= 1'b0;
        abort_out <= 1'b0;
        if (start_cond) begin
            // Also a repeated start; anything mid-byte is dropped
            abort_out <= (bit_cnt != `IEX_BIT_CNT_ZERO) &&
                         (state != ST_IDLE) && (state != ST_IGNORE);
            state <= ST_ADDR;
            bit_cnt <= `IEX_BIT_CNT_ZERO;
            sda_oe_n_out <= 1'b1;
            addressed_out <= 1'b0;
            read_mode_out <= 1'b0;
        end else if (stop_cond) begin
            abort_out <= (bit_cnt != `IEX_BIT_CNT_ZERO) &&
                         (state != ST_IDLE) && (state != ST_IGNORE);
            state <= ST_IDLE;
            bit_cnt <= `IEX_BIT_CNT_ZERO;
            sda_oe_n_out <= 1'b1;
            addressed_out <= 1'b0;
            read_mode_out <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    sda_oe_n_out <= 1'b1;
                end
                ST_ADDR, ST_WR_BYTE: begin
                    if (scl_rise) begin
                        // One bit per clock pulse, MSB first
                        shift <= {shift[`IEX_BYTE_W-2:0], sda};
                        bit_cnt <= bit_cnt + `IEX_BIT_CNT_ONE;
                    end else if (scl_fall && bit_cnt == `IEX_BITS_PER_BYTE) begin
                        bit_cnt <= `IEX_BIT_CNT_ZERO;
                        if (state == ST_ADDR) begin
                            if (shift[`IEX_BYTE_W-1:1] == own_addr) begin
                                sda_oe_n_out <= 1'b0;
                                addressed_out <= 1'b1;
                                read_mode_out <= (shift[0] == `IEX_DIR_READ);
                                first_byte <= 1'b1;
                                state <= ST_ADDR_ACK;
                            end else begin
                                sda_oe_n_out <= 1'b1;
                                state <= ST_IGNORE;
                            end
                        end else begin
                            sda_oe_n_out <= 1'b0;
                            first_byte <= 1'b0;
                            if (first_byte) begin
                                cmd_byte_out <= shift;
                                cmd_valid_out <= 1'b1;
                            end else begin
                                wr_data_out <= shift;
                                wr_valid_out <= 1'b1;
                            end
                            state <= ST_WR_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= `IEX_BIT_CNT_ZERO;
                        if (read_mode_out) begin
                            shift <= rd_data_in;
                            rd_load_out <= 1'b1;
                            sda_oe_n_out <= rd_data_in[`IEX_BYTE_W-1];
                            state <= ST_RD_BYTE;
                        end else begin
                            sda_oe_n_out <= 1'b1;
                            state <= ST_WR_BYTE;
                        end
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        sda_oe_n_out <= 1'b1;
                        state <= ST_WR_BYTE;
                    end
                end
                ST_RD_BYTE: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + `IEX_BIT_CNT_ONE;
                    end else if (scl_fall) begin
                        if (bit_cnt == `IEX_BITS_PER_BYTE) begin
                            sda_oe_n_out <= 1'b1;
                            bit_cnt <= `IEX_BIT_CNT_ZERO;
                            state <= ST_RD_ACK;
                        end else begin
                            shift <= {shift[`IEX_BYTE_W-2:0], 1'b0};
                            sda_oe_n_out <= shift[`IEX_BYTE_W-2];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        ctrl_acked <= ~sda;
                    end else if (scl_fall) begin
                        if (ctrl_acked) begin
                            shift <= rd_data_in;
                            rd_load_out <= 1'b1;
                            sda_oe_n_out <= rd_data_in[`IEX_BYTE_W-1];
                            state <= ST_RD_BYTE;
                        end else begin
                            sda_oe_n_out <= 1'b1;
                            state <= ST_IGNORE;
                        end
                    end
                end
                ST_IGNORE: begin
                    sda_oe_n_out <= 1'b1;
                end
                default: begin
                    state <= ST_IDLE;
                    sda_oe_n_out <= 1'b1;
                end
            endcase
        end
    end
end

endmodule

// >>> verif/iex_target_checker.sv
`timescale 1ns/1ps
module iex_target_checker (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic supply_good_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_oe_n_out,
    input wire logic [7:0] port_pins_oe_n_out,
    input wire logic regs_reset_out,
    input wire logic cmd_valid_out,
    input wire logic wr_valid_out,
    input wire logic rd_load_out,
    input wire logic addressed_out,
    input wire logic read_mode_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    ////////////////////////////////////////////////////////////////
    sequence s_start;
        scl_in && $past(scl_in) && $fell(sda_in);
    endsequence
    sequence s_stop;
        scl_in && $past(scl_in) && $rose(sda_in);
    endsequence
    sequence s_low_at_rise;
        $rose(scl_in) && !sda_oe_n_out;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_hold_inputs: assert property (
        regs_reset_out && $past(regs_reset_out) |-> port_pins_oe_n_out == 8'hff && sda_oe_n_out)
        else $error("pins or data line driven while held");
    a_supply_hold: assert property (
        !supply_good_in |-> ##[1:4] regs_reset_out)
        else $error("supply low without hold");
    a_start_drop: assert property (
        s_start |-> ##[1:6] !addressed_out)
        else $error("start did not end the transfer");
    a_stop_drop: assert property (
        s_stop |-> ##[1:6] !addressed_out)
        else $error("stop did not end the transfer");
    a_steady_high: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe_n_out))
        else $error("data line changed while clock high");
    a_ack_hold: assert property (
        s_low_at_rise |-> !sda_oe_n_out [*4])
        else $error("low bit not held through clock high");
    a_cmd_write: assert property (
        cmd_valid_out |-> addressed_out && !read_mode_out && !wr_valid_out)
        else $error("command byte outside a write");
    a_data_write: assert property (
        wr_valid_out |-> addressed_out && !read_mode_out)
        else $error("data byte outside a write");
    a_read_load: assert property (
        rd_load_out |-> read_mode_out && !scl_in)
        else $error("read byte loaded outside a read");
endmodule

bind iex_target iex_target_checker chk (.clk_in, .reset_n_in, .supply_good_in, .scl_in,
    .sda_in, .sda_oe_n_out, .port_pins_oe_n_out, .regs_reset_out, .cmd_valid_out,
    .wr_valid_out, .rd_load_out, .addressed_out, .read_mode_out);

// >>> verif/iex_ctrl_model.sv
`timescale 1ns/1ps
module iex_ctrl_model (
    input wire logic clk_in,
    input wire logic sda_wire_in,
    output logic scl_out = 1'b1,
    output logic sda_drv_out = 1'b1
);
    // Waits n edges, then sets both lines
    task automatic drive(input int n, input logic c, input logic d);
        repeat (n) @(posedge clk_in);
        scl_out <= c;
        sda_drv_out <= d;
    endtask
    // Data moves only while clock low, sampled mid high
    task automatic bit_x(input logic b, output logic r);
        drive(1, 1'b0, sda_drv_out);
        drive(2, 1'b0, b);
        drive(3, 1'b1, b);
        repeat (2) @(posedge clk_in);
        r = sda_wire_in;
    endtask
    // Also serves as repeated start
    task automatic start();
        drive(1, 1'b0, sda_drv_out);
        drive(2, 1'b0, 1'b1);
        drive(3, 1'b1, 1'b1);
        drive(3, 1'b1, 1'b0);
    endtask
    task automatic stop();
        drive(1, 1'b0, sda_drv_out);
        drive(2, 1'b0, 1'b0);
        drive(3, 1'b1, 1'b0);
        drive(3, 1'b1, 1'b1);
        repeat (6) @(posedge clk_in);
    endtask
    // Released data line (8'hff, a=1) lets the other side answer
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
        output logic ak);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(a, ak);
    endtask
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic supply_good_in = 1'b0;
    logic [2:0] address_select_inputs_in = 3'h0;
    logic [7:0] rd_data_in = 8'h00;
    logic [7:0] port_cfg_in = 8'h00;
    logic [7:0] port_data_in = 8'h00;
    wire scl_in, sda_drv, sda_out, sda_oe_n_out, regs_reset_out, cmd_valid_out;
    wire wr_valid_out, rd_load_out, addressed_out, read_mode_out, abort_out;
    wire [7:0] port_pins_out, port_pins_oe_n_out, cmd_byte_out, wr_data_out;
    wire sda_in = sda_drv & (sda_oe_n_out | sda_out);
    logic [31:0] seed = 32'h2cce8bdb;
    logic [7:0] got_cmd, got_wr, q, c, d, n0;
    logic [7:0] n_cmd = 8'h00;
    logic [7:0] n_abort = 8'h00;
    logic ak;
    logic [7:0] rq[$];
    int err_total = 0;
    int cmp_count = 0;

    always #50 clk_in = ~clk_in;

    iex_target dut (.clk_in, .reset_n_in, .supply_good_in, .scl_in, .sda_in,
        .address_select_inputs_in, .rd_data_in, .port_cfg_in, .port_data_in, .sda_out,
        .sda_oe_n_out, .port_pins_out, .port_pins_oe_n_out, .regs_reset_out, .cmd_byte_out,
        .cmd_valid_out, .wr_data_out, .wr_valid_out, .rd_load_out, .addressed_out,
        .read_mode_out, .abort_out);
    iex_ctrl_model ctrl (.clk_in, .sda_wire_in(sda_in), .scl_out(scl_in), .sda_drv_out(sda_drv));
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    function automatic logic [7:0] addr_byte(input logic [2:0] s, input logic dir);
        return {4'h3, s, dir};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 30 && regs_reset_out !== 1'b0; i++) @(posedge clk_in);
        check(regs_reset_out, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk_in) begin
        if (cmd_valid_out === 1'b1) begin
            got_cmd <= cmd_byte_out;
            n_cmd <= n_cmd + 8'h01;
        end
        if (wr_valid_out === 1'b1) got_wr <= wr_data_out;
        if (abort_out === 1'b1) n_abort <= n_abort + 8'h01;
        if (rd_load_out === 1'b1) begin
            rq.push_back(rd_data_in);
            rd_data_in <= rnd();
        end
    end

    initial begin
        #1_500_000;
        err_total++;
        results();
    end

    initial begin
        repeat (16) @(posedge clk_in);
        check({sda_oe_n_out, regs_reset_out, port_pins_oe_n_out}, 10'h3ff);
        reset_n_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        check(regs_reset_out, 1'b1);
        supply_good_in <= 1'b1;
        wait_ready();
        port_cfg_in <= rnd() & 8'h7f;
        port_data_in <= rnd();
        repeat (4) @(posedge clk_in);
        check({port_pins_oe_n_out, port_pins_out}, {port_cfg_in, port_data_in});
        for (int s = 0; s < 8; s++) begin
            address_select_inputs_in <= s[2:0];
            c = rnd();
            d = rnd();
            ctrl.start();
            ctrl.xfer(addr_byte(s[2:0], 1'b0), 1'b1, q, ak);
            check(ak, 1'b0);
            ctrl.xfer(c, 1'b1, q, ak);
            check({ak, got_cmd}, {1'b0, c});
            ctrl.xfer(d, 1'b1, q, ak);
            check({ak, got_wr, addressed_out}, {1'b0, d, 1'b1});
            ctrl.stop();
            check(addressed_out, 1'b0);
        end
        // First read byte is the all-zero starting value of the read data
        ctrl.start();
        ctrl.xfer(addr_byte(3'h7, 1'b1), 1'b1, q, ak);
        check({ak, read_mode_out}, 2'b01);
        for (int i = 0; i < 3; i++) begin
            ctrl.xfer(8'hff, i == 2, q, ak);
            check(q, rq.pop_front());
        end
        ctrl.drive(1, 1'b0, 1'b1);
        repeat (8) @(posedge clk_in);
        check({sda_oe_n_out, 8'(rq.size())}, 9'h100);
        ctrl.stop();
        // Select value 2 instead of 7, then wrong fixed pattern
        for (int i = 0; i < 2; i++) begin
            n0 = n_cmd;
            ctrl.start();
            ctrl.xfer(i ? 8'h2e : 8'h34, 1'b1, q, ak);
            ctrl.xfer(rnd(), 1'b1, q, c[0]);
            check({ak, c[0], n_cmd}, {2'b11, n0});
            ctrl.stop();
        end
        // Repeated start cuts a half-sent command byte
        ctrl.start();
        ctrl.xfer(addr_byte(3'h7, 1'b0), 1'b1, q, ak);
        for (int i = 0; i < 4; i++) ctrl.bit_x(1'b0, c[0]);
        n0 = n_abort;
        ctrl.start();
        ctrl.xfer(addr_byte(3'h7, 1'b0), 1'b1, q, c[1]);
        check({ak, c[1], n_abort - n0}, {2'b00, 8'h01});
        ctrl.stop();
        supply_good_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        check({regs_reset_out, port_pins_oe_n_out}, 9'h1ff);
        supply_good_in <= 1'b1;
        wait_ready();
        // Reset lands while the address acknowledge is being driven
        ctrl.start();
        ctrl.xfer(addr_byte(3'h7, 1'b0), 1'b1, q, ak);
        reset_n_in <= 1'b0;
        @(posedge clk_in);
        check({ak, regs_reset_out, sda_oe_n_out, addressed_out}, 4'h6);
        check({port_pins_oe_n_out, port_pins_out}, 16'hff00);
        reset_n_in <= 1'b1;
        wait_ready();
        ctrl.stop();
        results();
    end
endmodule
